/* design/scd_defines.svh */
`ifndef SCD_DEFINES_SVH
`define SCD_DEFINES_SVH
//------------------------------------------------------------------------------
// Overview of operation
// - Activate in idle bank latches row; special pin selects write-per-bit masking.
// - Refresh command starts auto or self refresh; only with every bank idle.
// - All-low command loads mode or special mode register per special pin.
// - Read in row-active bank starts burst, latches column, samples auto precharge.
// - Write in row-active bank latches column; special pin selects block write.
// - Column from address bits 0-7; precharge flag from address bit 9.
// - Row from address bits 0-9; bank from address bit 10.
// - Precharge to idle or precharging bank is no operation; flag precharges both.
// - No operation during plain burst lets burst finish, bank back to row-active.
// - Burst terminate ends burst, bank row-active; special pin high is illegal.
// - Precharge during read ends burst, precharges with read timing.
// - Precharge during write ends burst, precharges with write timing.
// - Auto precharge burst finishes then precharges; other commands to bank illegal.
// - Precharging bank goes idle after row precharge time; only no-ops allowed.
// - Block write recovery returns row-active after cycle time, or precharges if flagged; precharge may cut it.
// - Activating bank goes row-active after row-to-column delay; others illegal.
// - Auto refresh accepts only no-ops, all banks idle after row cycle time.
// - Illegal command is illegal only for the bank in that state.
// - Command decoding only when clock enable was high in the previous cycle.
// - Self refresh holds while enable low, exits on rise, then row cycle wait.
// - Power-down exit on enable rise; controller waits setup plus one clock.
// - Power-down and self refresh entered only from all banks idle.
// - Otherwise enable fall starts clock suspend, rise ends it next cycle.
//------------------------------------------------------------------------------

// Clock rate in megahertz, timing figures in nanoseconds.
`define SCD_CLK_MHZ 40
`define SCD_T_RCD_NS 20
`define SCD_T_RP_NS 20
`define SCD_T_RC_NS 70
`define SCD_T_BWC_NS 20
`define SCD_T_RDL_NS 10

// Derived cycle counts, least times rounded up.
`define SCD_RCD_CYC ((`SCD_T_RCD_NS * `SCD_CLK_MHZ + 999) / 1000)
`define SCD_RP_CYC ((`SCD_T_RP_NS * `SCD_CLK_MHZ + 999) / 1000)
`define SCD_RC_CYC ((`SCD_T_RC_NS * `SCD_CLK_MHZ + 999) / 1000)
`define SCD_BWC_CYC ((`SCD_T_BWC_NS * `SCD_CLK_MHZ + 999) / 1000)
`define SCD_RDL_CYC ((`SCD_T_RDL_NS * `SCD_CLK_MHZ + 999) / 1000)
`define SCD_BURST_LEN 4

// Address field positions.
`define SCD_COL_MSB 7
`define SCD_ROW_MSB 9
`define SCD_FLAG_BIT 9
`define SCD_BANK_BIT 10

// Event stream layout and buffer size.
`define SCD_EVT_WIDTH 16
`define SCD_EVT_DEPTH 8
`endif

/* design/scd_pkg.sv */
package scd_pkg;
  // Per-bank state, Gray coded along the usual path.
  typedef enum logic [3:0] {
    SCD_IDLE = 4'h0, SCD_ACTIVATING = 4'h1, SCD_ROW_ACTIVE = 4'h3, SCD_READ = 4'h2,
    SCD_WRITE = 4'h6, SCD_READ_AP = 4'h7, SCD_WRITE_AP = 4'h5, SCD_BW_RECOVER = 4'h4,
    SCD_PRECHARGING = 4'hC, SCD_REFRESHING = 4'hD
  } scd_bank_state_type;
  // Clock enable state of the whole device.
  typedef enum logic [1:0] {
    SCD_NORMAL = 2'h0, SCD_SUSPEND = 2'h1, SCD_POWER_DOWN = 2'h3, SCD_SELF_REFRESH = 2'h2
  } scd_pwr_state_type;
  // Decoded pin command.
  typedef enum logic [3:0] {
    SCD_DESEL = 4'h0, SCD_NOP = 4'h1, SCD_BST = 4'h2, SCD_RD = 4'h3, SCD_WR = 4'h4,
    SCD_ACT = 4'h5, SCD_PRE = 4'h6, SCD_REF = 4'h7, SCD_LOAD = 4'h8
  } scd_cmd_type;
endpackage

/* design/scd_decoder.sv */
`timescale 1ns/1ps
`include "scd_defines.svh"

//------------------------------------------------------------------------------
// Event buffer
//------------------------------------------------------------------------------
module scd_fifo #(
  parameter int WIDTH = `SCD_EVT_WIDTH,
  parameter int DEPTH = `SCD_EVT_DEPTH
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Filling side.
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Draining side.
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0] cnt_ff, nxt_cnt;
  logic [AW-1:0] wr_ff, rd_ff, nxt_wr, nxt_rd;
  logic push, pop;

  // Pointer and fill level update.
  always_comb begin
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    nxt_wr = push ? ((wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1) : wr_ff;
    nxt_rd = pop ? ((rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1) : rd_ff;
    nxt_cnt = cnt_ff + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  // Registers of the buffer.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
    end
    if (push) begin
      mem_ff[wr_ff] <= in_data_i;
    end
  end

  // Full and empty come straight from the fill level.
  assign in_ready_o = (cnt_ff != (AW + 1)'(DEPTH));
  assign out_valid_o = (cnt_ff != '0);
  assign out_data_o = mem_ff[rd_ff];
endmodule

//------------------------------------------------------------------------------
// Command decoder and bank state machines
//------------------------------------------------------------------------------
module scd_decoder (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Command and address pins.
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic special_function_select_i,
  input wire logic [10:0] addr_i,
  // Bank status.
  output logic [3:0] bank0_state_o,
  output logic [3:0] bank1_state_o,
  output logic [9:0] row_addr_field0_o,
  output logic [9:0] row_addr_field1_o,
  output logic [1:0] write_mask_en_o,
  output logic [7:0] column_addr_field_o,
  output logic auto_precharge_flag_o,
  output logic all_banks_idle_state_o,
  // Mode loads and errors.
  output logic mode_load_o,
  output logic special_mode_load_o,
  output logic [10:0] mode_opcode_o,
  output logic [10:0] special_opcode_o,
  output logic illegal_cmd_o,
  output logic event_drop_o,
  // Clock enable status.
  output logic power_down_o,
  output logic self_refresh_o,
  output logic clock_suspend_o,
  // Accepted command stream.
  output logic evt_in_ready_o,
  output logic evt_valid_o,
  output logic [15:0] evt_data_o,
  input wire logic evt_ready_i
);
  localparam int RCD_N = `SCD_RCD_CYC;
  localparam int RP_N = `SCD_RP_CYC;
  localparam logic [3:0] RCD_C = 4'(`SCD_RCD_CYC);
  localparam logic [3:0] RP_C = 4'(`SCD_RP_CYC);
  localparam logic [3:0] RP_WR_C = 4'(`SCD_RP_CYC + `SCD_RDL_CYC);
  localparam logic [3:0] RP_BW_C = 4'(`SCD_RP_CYC + `SCD_BWC_CYC);
  localparam logic [3:0] RC_C = 4'(`SCD_RC_CYC);
  localparam logic [3:0] BWC_C = 4'(`SCD_BWC_CYC);
  localparam logic [3:0] BL_C = 4'(`SCD_BURST_LEN);

  scd_pkg::scd_cmd_type cmd;
  scd_pkg::scd_bank_state_type st_ff [2];
  scd_pkg::scd_pwr_state_type pwr_ff, nxt_pwr;
  logic [1:0] bad;
  logic cke_prev_ff, exec, run, all_idle, special_function_select, flag, sr_exit, acc;
  logic illegal_ff, nxt_illegal, mload_ff, nxt_mload, sload_ff, nxt_sload;
  logic [10:0] mop_ff, nxt_mop, sop_ff, nxt_sop;
  logic [7:0] col_ff, nxt_col;
  logic ap_ff, nxt_ap, drop_ff, nxt_drop, evt_valid;
  logic [15:0] evt_word;

  // Pin command decode.
  always_comb begin
    if (cs_n_i) begin
      cmd = scd_pkg::SCD_DESEL;
    end else begin
      case ({ras_n_i, cas_n_i, we_n_i})
        3'h7: cmd = scd_pkg::SCD_NOP;
        3'h6: cmd = scd_pkg::SCD_BST;
        3'h5: cmd = scd_pkg::SCD_RD;
        3'h4: cmd = scd_pkg::SCD_WR;
        3'h3: cmd = scd_pkg::SCD_ACT;
        3'h2: cmd = scd_pkg::SCD_PRE;
        3'h1: cmd = scd_pkg::SCD_REF;
        default: cmd = scd_pkg::SCD_LOAD;
      endcase
    end
  end

  // Common qualifiers; commands only act after a cycle with clock enable high.
  assign special_function_select = special_function_select_i;
  assign flag = addr_i[`SCD_FLAG_BIT];
  assign exec = cke_prev_ff && (pwr_ff == scd_pkg::SCD_NORMAL);
  assign run = (pwr_ff == scd_pkg::SCD_NORMAL);
  assign all_idle = (st_ff[0] == scd_pkg::SCD_IDLE) && (st_ff[1] == scd_pkg::SCD_IDLE);
  assign sr_exit = (pwr_ff == scd_pkg::SCD_SELF_REFRESH) && !cke_prev_ff && cke_i;

  // One state machine per bank, each checked against its own state; refresh is checked against both banks.
  for (genvar b = 0; b < 2; b++) begin : g_bank
    scd_pkg::scd_bank_state_type nxt_st;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [9:0] row_ff, nxt_row;
    logic wpb_ff, nxt_wpb, ap_b_ff, nxt_ap_b, sel, col_ok, busy;

    always_comb begin
      sel = (addr_i[`SCD_BANK_BIT] == 1'(b));
      col_ok = (st_ff[b] == scd_pkg::SCD_ROW_ACTIVE) || (st_ff[b] == scd_pkg::SCD_READ) ||
               (st_ff[b] == scd_pkg::SCD_WRITE);
      busy = (st_ff[b] == scd_pkg::SCD_READ) || (st_ff[b] == scd_pkg::SCD_WRITE);
      nxt_st = st_ff[b];
      nxt_cnt = cnt_ff;
      nxt_row = row_ff;
      nxt_wpb = wpb_ff;
      nxt_ap_b = ap_b_ff;
      bad[b] = 1'b0;
      if (run && (cnt_ff != 4'h0)) begin
        nxt_cnt = cnt_ff - 4'h1;
      end
      // Timed transitions when the running count expires.
      if (run && (cnt_ff == 4'h1)) begin
        case (st_ff[b])
          scd_pkg::SCD_ACTIVATING: nxt_st = scd_pkg::SCD_ROW_ACTIVE;
          scd_pkg::SCD_READ, scd_pkg::SCD_WRITE: nxt_st = scd_pkg::SCD_ROW_ACTIVE;
          scd_pkg::SCD_READ_AP, scd_pkg::SCD_WRITE_AP: begin
            nxt_st = scd_pkg::SCD_PRECHARGING;
            nxt_cnt = RP_C;
          end
          scd_pkg::SCD_BW_RECOVER: begin
            nxt_st = ap_b_ff ? scd_pkg::SCD_PRECHARGING : scd_pkg::SCD_ROW_ACTIVE;
            nxt_cnt = ap_b_ff ? RP_C : 4'h0;
          end
          scd_pkg::SCD_PRECHARGING: nxt_st = scd_pkg::SCD_IDLE;
          scd_pkg::SCD_REFRESHING: nxt_st = scd_pkg::SCD_IDLE;
          default: nxt_st = st_ff[b];
        endcase
      end
      if (sr_exit) begin
        nxt_st = scd_pkg::SCD_REFRESHING;
        nxt_cnt = RC_C;
      end
      // Command actions for this bank.
      if (exec) begin
        case (cmd)
          scd_pkg::SCD_ACT: begin
            if (sel && st_ff[b] == scd_pkg::SCD_IDLE) begin
              nxt_st = scd_pkg::SCD_ACTIVATING;
              nxt_cnt = RCD_C;
              nxt_row = addr_i[`SCD_ROW_MSB:0];
              nxt_wpb = special_function_select;
            end else if (sel) begin
              bad[b] = 1'b1;
            end
          end
          scd_pkg::SCD_RD, scd_pkg::SCD_WR: begin
            if (sel && col_ok && !(special_function_select && cmd == scd_pkg::SCD_RD)) begin
              nxt_ap_b = flag;
              nxt_cnt = BL_C;
              if (cmd == scd_pkg::SCD_RD) begin
                nxt_st = flag ? scd_pkg::SCD_READ_AP : scd_pkg::SCD_READ;
              end else if (special_function_select) begin
                nxt_st = scd_pkg::SCD_BW_RECOVER;
                nxt_cnt = BWC_C;
              end else begin
                nxt_st = flag ? scd_pkg::SCD_WRITE_AP : scd_pkg::SCD_WRITE;
              end
            end else if (sel) begin
              bad[b] = 1'b1;
            end else if (busy) begin
              nxt_st = scd_pkg::SCD_ROW_ACTIVE;
              nxt_cnt = 4'h0;
            end
          end
          scd_pkg::SCD_PRE: begin
            if ((sel || flag) && special_function_select) begin
              bad[b] = sel;
            end else if (sel || flag) begin
              case (st_ff[b])
                scd_pkg::SCD_IDLE, scd_pkg::SCD_PRECHARGING: nxt_st = st_ff[b];
                scd_pkg::SCD_ROW_ACTIVE, scd_pkg::SCD_READ: begin
                  nxt_st = scd_pkg::SCD_PRECHARGING;
                  nxt_cnt = RP_C;
                end
                scd_pkg::SCD_WRITE: begin
                  nxt_st = scd_pkg::SCD_PRECHARGING;
                  nxt_cnt = RP_WR_C;
                end
                scd_pkg::SCD_BW_RECOVER: begin
                  nxt_st = scd_pkg::SCD_PRECHARGING;
                  nxt_cnt = RP_BW_C;
                end
                default: bad[b] = sel;
              endcase
            end
          end
          scd_pkg::SCD_BST: begin
            if (busy && !special_function_select) begin
              nxt_st = scd_pkg::SCD_ROW_ACTIVE;
              nxt_cnt = 4'h0;
            end else if (busy || st_ff[b] == scd_pkg::SCD_READ_AP || st_ff[b] == scd_pkg::SCD_WRITE_AP) begin
              bad[b] = 1'b1;
            end
          end
          scd_pkg::SCD_REF: begin
            if (special_function_select || !all_idle) begin
              bad[b] = 1'b1;
            end else if (cke_i) begin
              nxt_st = scd_pkg::SCD_REFRESHING;
              nxt_cnt = RC_C;
            end
          end
          scd_pkg::SCD_LOAD: begin
            if (!special_function_select) begin
              bad[b] = (st_ff[b] != scd_pkg::SCD_IDLE);
            end else begin
              bad[b] = (st_ff[b] != scd_pkg::SCD_IDLE) && (st_ff[b] != scd_pkg::SCD_ROW_ACTIVE);
            end
          end
          default: bad[b] = 1'b0;
        endcase
      end
    end

    always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
        st_ff[b] <= scd_pkg::SCD_IDLE;
        cnt_ff <= 4'h0;
        row_ff <= 10'h000;
        wpb_ff <= 1'b0;
        ap_b_ff <= 1'b0;
      end else begin
        st_ff[b] <= nxt_st;
        cnt_ff <= nxt_cnt;
        row_ff <= nxt_row;
        wpb_ff <= nxt_wpb;
        ap_b_ff <= nxt_ap_b;
      end
    end
  end

  // Clock enable handling, mode loads, column latch and the error flag.
  always_comb begin
    nxt_pwr = pwr_ff;
    nxt_illegal = exec && (bad != 2'h0);
    nxt_mload = 1'b0;
    nxt_sload = 1'b0;
    nxt_mop = mop_ff;
    nxt_sop = sop_ff;
    nxt_col = col_ff;
    nxt_ap = ap_ff;
    case (pwr_ff)
      scd_pkg::SCD_NORMAL: begin
        if (cke_prev_ff && !cke_i) begin
          if (all_idle && (cmd == scd_pkg::SCD_DESEL || cmd == scd_pkg::SCD_NOP)) begin
            nxt_pwr = scd_pkg::SCD_POWER_DOWN;
          end else if (all_idle && cmd == scd_pkg::SCD_REF && !special_function_select) begin
            nxt_pwr = scd_pkg::SCD_SELF_REFRESH;
          end else begin
            nxt_pwr = scd_pkg::SCD_SUSPEND;
          end
        end
      end
      scd_pkg::SCD_SUSPEND: begin
        if (!cke_prev_ff && cke_i) begin
          nxt_pwr = scd_pkg::SCD_NORMAL;
        end
      end
      default: begin
        if (!cke_prev_ff && cke_i) begin
          nxt_pwr = scd_pkg::SCD_NORMAL;
          nxt_illegal = (cmd != scd_pkg::SCD_DESEL) && (cmd != scd_pkg::SCD_NOP);
        end
      end
    endcase
    if (exec && bad == 2'h0) begin
      if (cmd == scd_pkg::SCD_LOAD && !special_function_select) begin
        nxt_mload = 1'b1;
        nxt_mop = addr_i;
      end
      if (cmd == scd_pkg::SCD_LOAD && special_function_select) begin
        nxt_sload = 1'b1;
        nxt_sop = addr_i;
      end
      if (cmd == scd_pkg::SCD_RD || cmd == scd_pkg::SCD_WR) begin
        nxt_col = addr_i[`SCD_COL_MSB:0];
        nxt_ap = flag;
      end
    end
  end

  // Accepted commands go into the event buffer; a full buffer drops them.
  assign acc = exec && (bad == 2'h0) && (cmd != scd_pkg::SCD_DESEL) && (cmd != scd_pkg::SCD_NOP);
  assign evt_valid = acc;
  assign evt_word = {cmd, special_function_select, addr_i};
  assign nxt_drop = acc && !evt_in_ready_o;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pwr_ff <= scd_pkg::SCD_NORMAL;
      cke_prev_ff <= 1'b1;
      illegal_ff <= 1'b0;
      mload_ff <= 1'b0;
      sload_ff <= 1'b0;
      mop_ff <= 11'h000;
      sop_ff <= 11'h000;
      col_ff <= 8'h00;
      ap_ff <= 1'b0;
      drop_ff <= 1'b0;
    end else begin
      pwr_ff <= nxt_pwr;
      cke_prev_ff <= cke_i;
      illegal_ff <= nxt_illegal;
      mload_ff <= nxt_mload;
      sload_ff <= nxt_sload;
      mop_ff <= nxt_mop;
      sop_ff <= nxt_sop;
      col_ff <= nxt_col;
      ap_ff <= nxt_ap;
      drop_ff <= nxt_drop;
    end
  end

  scd_fifo #(.WIDTH(`SCD_EVT_WIDTH), .DEPTH(`SCD_EVT_DEPTH)) u_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .in_valid_i(evt_valid),
    .in_data_i(evt_word),
    .in_ready_o(evt_in_ready_o),
    .out_valid_o(evt_valid_o),
    .out_data_o(evt_data_o),
    .out_ready_i(evt_ready_i)
  );

  // Output assignments.
  assign bank0_state_o = st_ff[0];
  assign bank1_state_o = st_ff[1];
  assign row_addr_field0_o = g_bank[0].row_ff;
  assign row_addr_field1_o = g_bank[1].row_ff;
  assign write_mask_en_o = {g_bank[1].wpb_ff, g_bank[0].wpb_ff};
  assign column_addr_field_o = col_ff;
  assign auto_precharge_flag_o = ap_ff;
  assign all_banks_idle_state_o = all_idle;
  assign mode_load_o = mload_ff;
  assign special_mode_load_o = sload_ff;
  assign mode_opcode_o = mop_ff;
  assign special_opcode_o = sop_ff;
  assign illegal_cmd_o = illegal_ff;
  assign event_drop_o = drop_ff;
  assign power_down_o = (pwr_ff == scd_pkg::SCD_POWER_DOWN);
  assign self_refresh_o = (pwr_ff == scd_pkg::SCD_SELF_REFRESH);
  assign clock_suspend_o = (pwr_ff == scd_pkg::SCD_SUSPEND);

  // Checks on the decoder behaviour.
  act_opens_row_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    exec && cmd == scd_pkg::SCD_ACT && !addr_i[10] && st_ff[0] == scd_pkg::SCD_IDLE
    |=> st_ff[0] == scd_pkg::SCD_ACTIVATING && write_mask_en_o[0] == $past(special_function_select) &&
        row_addr_field0_o == $past(addr_i[9:0]))
    else $error("activate did not open bank 0");
  refresh_start_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    exec && cmd == scd_pkg::SCD_REF && !special_function_select && all_idle && cke_i
    |=> st_ff[0] == scd_pkg::SCD_REFRESHING && st_ff[1] == scd_pkg::SCD_REFRESHING)
    else $error("auto refresh did not start");
  mode_load_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    exec && cmd == scd_pkg::SCD_LOAD && !special_function_select && all_idle
    |=> mode_load_o && !special_mode_load_o && mode_opcode_o == $past(addr_i))
    else $error("mode load missed");
  read_begin_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    exec && cmd == scd_pkg::SCD_RD && !special_function_select && !addr_i[10] && st_ff[0] == scd_pkg::SCD_ROW_ACTIVE
    |=> (st_ff[0] == (auto_precharge_flag_o ? scd_pkg::SCD_READ_AP : scd_pkg::SCD_READ)) &&
        column_addr_field_o == $past(addr_i[7:0]))
    else $error("read burst did not begin");
  block_write_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    exec && cmd == scd_pkg::SCD_WR && special_function_select && !addr_i[10] && st_ff[0] == scd_pkg::SCD_ROW_ACTIVE
    |=> st_ff[0] == scd_pkg::SCD_BW_RECOVER)
    else $error("block write did not start recovery");
  pre_idle_nop_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    exec && cmd == scd_pkg::SCD_PRE && !special_function_select && !addr_i[10] && !addr_i[9] &&
    st_ff[0] == scd_pkg::SCD_IDLE && !sr_exit
    |=> st_ff[0] == scd_pkg::SCD_IDLE && !illegal_cmd_o)
    else $error("precharge to idle bank was not a no-op");
  burst_stop_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    exec && cmd == scd_pkg::SCD_BST && !special_function_select && st_ff[0] == scd_pkg::SCD_WRITE
    |=> st_ff[0] == scd_pkg::SCD_ROW_ACTIVE)
    else $error("burst terminate did not end write burst");
  rcd_wait_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    st_ff[0] == scd_pkg::SCD_IDLE ##1 st_ff[0] == scd_pkg::SCD_ACTIVATING && run
    |-> ##RCD_N st_ff[0] != scd_pkg::SCD_ACTIVATING)
    else $error("activating outlasted row to column delay");
  rp_wait_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(st_ff[0] == scd_pkg::SCD_PRECHARGING) && run && cke_i && cke_prev_ff
    |-> int'(g_bank[0].cnt_ff) >= RP_N)
    else $error("precharge count shorter than row precharge time");
  pd_entry_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(power_down_o) || $rose(self_refresh_o) |-> $past(all_idle))
    else $error("low power entered with open bank");
  other_bank_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    exec && cmd == scd_pkg::SCD_ACT && addr_i[10] && st_ff[0] == scd_pkg::SCD_ROW_ACTIVE &&
    st_ff[1] == scd_pkg::SCD_IDLE |=> !illegal_cmd_o)
    else $error("activate to idle bank flagged by the other bank");
endmodule

/* sim/scd_ctrl_model.sv */
`timescale 1ns/1ps
// Controller model that issues one command per call and deselects between commands.
module scd_ctrl_model (
  // Clock.
  input wire logic sys_clk_i,
  // Command and address pins.
  output logic cke_o,
  output logic cs_n_o,
  output logic ras_n_o,
  output logic cas_n_o,
  output logic we_n_o,
  output logic dsf_o,
  output logic [10:0] addr_o
);
  // Pins start deselected with clock enable high.
  initial begin
    {cke_o, cs_n_o, ras_n_o, cas_n_o, we_n_o, dsf_o} = 6'h3F;
    addr_o = 11'h000;
  end

  // Drives a command after an edge, holds it through the next edge, then deselects.
  task automatic send(input logic k, input logic [2:0] rcw, input logic special_function_select, input logic [10:0] a);
    @(posedge sys_clk_i);
    #2;
    {cke_o, cs_n_o, ras_n_o, cas_n_o, we_n_o, dsf_o} = {k, 1'b0, rcw, special_function_select};
    addr_o = a;
    @(posedge sys_clk_i);
    #2;
    cs_n_o = 1'b1;
    {ras_n_o, cas_n_o, we_n_o, dsf_o} = ~{rcw, special_function_select};
    addr_o = ~a;
  endtask
endmodule

/* sim/test_sgram_command_state_decoder.sv */
`timescale 1ns/1ps
// Bench for the command decoder.
module test_sgram_command_state_decoder;
  //----------------------------------------------------------------------------
  // Signals
  //----------------------------------------------------------------------------
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic evt_ready_i = 1'b0;
  logic [1:0] rdy_mode = 2'h2;
  logic cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, special_function_select_i;
  logic [10:0] addr_i, mode_opcode_o;
  logic [3:0] bank0_state_o, bank1_state_o;
  logic [9:0] row_addr_field0_o, row_addr_field1_o, row;
  logic [10:0] special_opcode_o;
  logic special_mode_load_o, self_refresh_o, clock_suspend_o;
  logic [7:0] column_addr_field_o, col;
  logic [1:0] write_mask_en_o;
  logic [15:0] evt_data_o;
  logic auto_precharge_flag_o, all_banks_idle_state_o, mode_load_o, illegal_cmd_o;
  logic event_drop_o, power_down_o, evt_in_ready_o, evt_valid_o;
  logic [15:0] exp_q[$];
  int miscompares = 0;
  int n_checks = 0;

  // Clock generation.
  always #12.5 sys_clk_i = ~sys_clk_i;

  scd_ctrl_model m (.sys_clk_i, .cke_o(cke_i), .cs_n_o(cs_n_i), .ras_n_o(ras_n_i), .cas_n_o(cas_n_i),
    .we_n_o(we_n_i), .dsf_o(special_function_select_i), .addr_o(addr_i));

  scd_decoder dut_u (.sys_clk_i, .rst_i, .cke_i, .cs_n_i, .ras_n_i, .cas_n_i, .we_n_i,
    .special_function_select_i, .addr_i, .bank0_state_o, .bank1_state_o, .row_addr_field0_o,
    .row_addr_field1_o, .write_mask_en_o, .column_addr_field_o, .auto_precharge_flag_o,
    .all_banks_idle_state_o, .mode_load_o, .special_mode_load_o, .mode_opcode_o,
    .special_opcode_o, .illegal_cmd_o, .event_drop_o, .power_down_o, .self_refresh_o,
    .clock_suspend_o, .evt_in_ready_o, .evt_valid_o, .evt_data_o, .evt_ready_i);

  //----------------------------------------------------------------------------
  // Tasks
  //----------------------------------------------------------------------------
  // Compares one value and counts the result.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Notes the expected stream word when a code is given, then issues the command.
  task automatic go(input logic k, input logic [2:0] rcw, input logic special_function_select, input logic [10:0] a,
                    input logic [3:0] code);
    if (code != 4'h0) exp_q.push_back({code, special_function_select, a});
    m.send(k, rcw, special_function_select, a);
  endtask

  // Waits some edges and lets their updates land.
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #2;
  endtask

  // Drain ready: random, held low or held high.
  always @(posedge sys_clk_i) begin
    #2;
    evt_ready_i = rdy_mode[1] ? 1'($urandom) : rdy_mode[0];
  end

  // Takes the oldest note whenever a stream word is popped.
  always @(posedge sys_clk_i) begin
    if (evt_valid_o === 1'b1 && evt_ready_i === 1'b1) begin
      if (exp_q.size() == 0) check(evt_data_o, 16'hFFFF);
      else check(evt_data_o, exp_q.pop_front());
    end
  end

  // Watchdog.
  initial begin
    #20000;
    miscompares++;
    summarize();
  end

  //----------------------------------------------------------------------------
  // Tests
  //----------------------------------------------------------------------------
  initial begin
    void'($urandom(87));
    row = 10'($urandom);
    col = 8'($urandom);
    tick(5);
    rst_i = 1'b0;
    go(1'b1, 3'b011, 1'b1, {1'b0, row}, scd_pkg::SCD_ACT);
    check(bank0_state_o, 4'h1);
    check(row_addr_field0_o, row);
    check(write_mask_en_o, 2'h1);
    tick(1);
    check(bank0_state_o, 4'h3);
    go(1'b1, 3'b101, 1'b0, {3'h0, col}, scd_pkg::SCD_RD);
    check(bank0_state_o, 4'h2);
    check(column_addr_field_o, col);
    check(auto_precharge_flag_o, 1'b0);
    tick(4);
    check(bank0_state_o, 4'h3);
    go(1'b1, 3'b101, 1'b0, {3'h4, col}, 4'h0);
    check(illegal_cmd_o, 1'b1);
    check(bank0_state_o, 4'h3);
    go(1'b1, 3'b101, 1'b1, {3'h0, col}, 4'h0);
    check(illegal_cmd_o, 1'b1);
    go(1'b1, 3'b011, 1'b0, {1'b1, ~row}, scd_pkg::SCD_ACT);
    check(illegal_cmd_o, 1'b0);
    check(row_addr_field1_o, 10'(~row));
    go(1'b1, 3'b000, 1'b1, {3'h0, col}, scd_pkg::SCD_LOAD);
    check(special_mode_load_o, 1'b1);
    check(special_opcode_o, {3'h0, col});
    $display("activate and read done");
    go(1'b1, 3'b100, 1'b1, {3'h0, ~col}, scd_pkg::SCD_WR);
    check(bank0_state_o, 4'h4);
    tick(1);
    check(bank0_state_o, 4'h3);
    go(1'b0, 3'b111, 1'b0, 11'h000, 4'h0);
    check(clock_suspend_o, 1'b1);
    go(1'b1, 3'b111, 1'b0, 11'h000, 4'h0);
    check(clock_suspend_o, 1'b0);
    go(1'b1, 3'b100, 1'b0, {3'h0, col}, scd_pkg::SCD_WR);
    go(1'b1, 3'b110, 1'b0, 11'h000, scd_pkg::SCD_BST);
    check(bank0_state_o, 4'h3);
    go(1'b1, 3'b010, 1'b0, 11'h200, scd_pkg::SCD_PRE);
    check(bank0_state_o, 4'hC);
    tick(1);
    check(all_banks_idle_state_o, 1'b1);
    go(1'b1, 3'b010, 1'b0, 11'h000, scd_pkg::SCD_PRE);
    check(illegal_cmd_o, 1'b0);
    check(bank0_state_o, 4'h0);
    $display("write and precharge done");
    go(1'b1, 3'b001, 1'b0, 11'h000, scd_pkg::SCD_REF);
    check({bank0_state_o, bank1_state_o}, 8'hDD);
    tick(3);
    check({bank0_state_o, bank1_state_o}, 8'h00);
    go(1'b1, 3'b000, 1'b0, {1'b0, row}, scd_pkg::SCD_LOAD);
    check(mode_load_o, 1'b1);
    check(mode_opcode_o, {1'b0, row});
    go(1'b0, 3'b111, 1'b0, 11'h000, 4'h0);
    check(power_down_o, 1'b1);
    go(1'b1, 3'b111, 1'b0, 11'h000, 4'h0);
    check(power_down_o, 1'b0);
    go(1'b0, 3'b001, 1'b0, 11'h000, scd_pkg::SCD_REF);
    check(self_refresh_o, 1'b1);
    go(1'b1, 3'b111, 1'b0, 11'h000, 4'h0);
    check(self_refresh_o, 1'b0);
    check({bank0_state_o, bank1_state_o}, 8'hDD);
    $display("refresh, load and power-down done");
    rdy_mode = 2'h1;
    tick(12);
    check(16'(exp_q.size()), 16'h0000);
    rdy_mode = 2'h0;
    for (int i = 0; i < 9; i++) go(1'b1, 3'b000, 1'b0, 11'(i), (i < 8) ? scd_pkg::SCD_LOAD : 4'h0);
    check(event_drop_o, 1'b1);
    check(evt_in_ready_o, 1'b0);
    rdy_mode = 2'h1;
    tick(12);
    check(16'(exp_q.size()), 16'h0000);
    $display("buffer fill and drain done");
    summarize();
  end
endmodule
